// >>> tb/opc_output_pll_control_properties.sv
`timescale 1ns/1ps
module opc_output_pll_control_properties import opc_pkg::*; (
  input wire logic       clock_in, rst_b_in, wr_en_in, rd_en_in,
  input wire logic [9:0] addr_in,
  input wire logic [7:0] wdata_in, rdata_out, cp_current_out, fb_n_out,
  input wire logic       lock_det_pd_out, ref_doubler_out,
  input wire logic [1:0] antibacklash_out, cp_mode_out);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  sequence ctl_wr; wr_en_in && addr_in == OPC_ADDR_CONTROL; endsequence
  cp_code_a: assert property (wr_en_in && addr_in == OPC_ADDR_CP_CURRENT |-> ##2
    cp_current_out == $past(wdata_in, 2)) else $error("pump code wrong");
  fb_div_a: assert property (wr_en_in && addr_in == OPC_ADDR_FB_DIV |-> ##2
    fb_n_out == 4 * $past(wdata_in[5:0], 2) + $past(wdata_in[7:6], 2)) else $error("N wrong");
  lock_pd_a: assert property (ctl_wr |-> ##2
    lock_det_pd_out == $past(wdata_in[7], 2)) else $error("power down wrong");
  doubler_a: assert property (ctl_wr |-> ##2
    ref_doubler_out == $past(wdata_in[5], 2)) else $error("doubler wrong");
  abl_forced_a: assert property (ctl_wr and !wdata_in[4] |-> ##2
    antibacklash_out == OPC_ABL_HIGH) else $error("width not forced");
  abl_field_a: assert property (ctl_wr and wdata_in[4] |-> ##2
    antibacklash_out == $past(wdata_in[3:2], 2)) else $error("width wrong");
  pump_mode_a: assert property (ctl_wr |-> ##2
    cp_mode_out == $past(wdata_in[1:0], 2)) else $error("pump mode wrong");
  outputs_hold_a: assert property (!wr_en_in [*3] |->
    $stable({cp_current_out, fb_n_out, cp_mode_out})) else $error("output moved");
  unmapped_read_a: assert property (rd_en_in && addr_in > OPC_ADDR_CONTROL |=>
    rdata_out == 8'h00) else $error("unmapped read not zero");
endmodule : opc_output_pll_control_properties

// >>> tb/test_output_pll_control_settings.sv
`timescale 1ns/1ps
module test_output_pll_control_settings;
  import opc_pkg::*;
  logic       clock_in = 0, rst_b_in = 0, wr_en_in = 0, rd_en_in = 0;
  logic [9:0] addr_in = 10'h000;
  logic [7:0] wdata_in = 8'h00, rdata_out, cp_current_out, fb_n_out;
  logic       lock_det_pd_out, ref_doubler_out;
  logic [1:0] antibacklash_out, cp_mode_out;
  int         num_errors = 0, comparisons = 0, cycles = 0;
  wire  [7:0] ctl_out = {2'h0, lock_det_pd_out, ref_doubler_out, antibacklash_out, cp_mode_out};
  opc_output_pll_control opc_output_pll_control_i (
    .clock_in         (clock_in),
    .rst_b_in         (rst_b_in),
    .wr_en_in         (wr_en_in),
    .rd_en_in         (rd_en_in),
    .addr_in          (addr_in),
    .wdata_in         (wdata_in),
    .rdata_out        (rdata_out),
    .cp_current_out   (cp_current_out),
    .fb_n_out         (fb_n_out),
    .lock_det_pd_out  (lock_det_pd_out),
    .ref_doubler_out  (ref_doubler_out),
    .antibacklash_out (antibacklash_out),
    .cp_mode_out      (cp_mode_out)
  );
  always #12.5 clock_in = ~clock_in;
  task automatic chk(input logic [7:0] g, e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clock_in) #1 {wr_en_in, addr_in, wdata_in} = {1'b1, a, d};
    @(posedge clock_in) #1 wr_en_in = 1'b0;
    repeat (2) @(posedge clock_in);
    #1;
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    @(posedge clock_in) #1 {rd_en_in, addr_in} = {1'b1, a};
    @(posedge clock_in) #1 rd_en_in = 1'b0;
    chk(rdata_out, e);
  endtask : rd
  task automatic reset_values;
    chk(cp_current_out, 8'h00);
    chk(ctl_out, 8'h0b);
    rd(OPC_ADDR_CONTROL, 8'h0b);
  endtask : reset_values
  task automatic data_regs;
    wr(OPC_ADDR_CP_CURRENT, 8'hff);
    rd(OPC_ADDR_CP_CURRENT, 8'hff);
    chk(cp_current_out, 8'hff);
    wr(OPC_ADDR_FB_DIV, 8'h87);
    chk(fb_n_out, 8'h1e);
    wr(OPC_ADDR_FB_DIV, 8'hff);
    chk(fb_n_out, 8'hff);
    rd(OPC_ADDR_FB_DIV, 8'hff);
    wr(10'h0f3, 8'h55);
    rd(10'h0f3, 8'h00);
    rd(OPC_ADDR_CP_CURRENT, 8'hff);
  endtask : data_regs
  task automatic mid_reset;
    wr(OPC_ADDR_FB_DIV, 8'h45);
    chk(fb_n_out, 8'h15);
    @(posedge clock_in) #1 rst_b_in = 1'b0;
    repeat (2) @(posedge clock_in);
    #1 rst_b_in = 1'b1;
    chk(fb_n_out, 8'h00);
    chk(ctl_out, 8'h0b);
    rd(OPC_ADDR_FB_DIV, 8'h00);
    rd(OPC_ADDR_CONTROL, 8'h0b);
  endtask : mid_reset
  task automatic control_modes;
    for (int i = 0; i < 4; i++) begin
      wr(OPC_ADDR_CONTROL, 8'hb0 | 8'(i * 5));
      chk(ctl_out, 8'h30 | 8'(i * 5));
    end
    wr(OPC_ADDR_CONTROL, 8'h0c);
    chk(ctl_out, 8'h08);
    rd(OPC_ADDR_CONTROL, 8'h0c);
  endtask : control_modes
  task automatic print_verdict;
    $display("Errors %0d, comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 1000) begin
      num_errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (4) @(posedge clock_in);
    #1 rst_b_in = 1'b1;
    reset_values();
    data_regs();
    control_modes();
    mid_reset();
    print_verdict();
  end
endmodule : test_output_pll_control_settings
bind opc_output_pll_control opc_output_pll_control_properties opc_output_pll_control_properties_i (.*);

// >>> verilog/opc_decode.sv
`timescale 1ns/1ps
module opc_decode (
  opc_if.dec bus
);
  import opc_pkg::*;
  // ==========================================================================
  // Field decode
  wire [1:0] a_cnt = bus.fb[OPC_A_HI:OPC_A_LO];
  wire [5:0] b_cnt = bus.fb[OPC_B_HI:OPC_B_LO];
  assign bus.n_div = (8'(b_cnt) << OPC_N_SHIFT) + 8'(a_cnt);   // RULE_02
  assign bus.ld_pd = bus.ctrl[OPC_BIT_LD_PD];                     // RULE_04
  assign bus.dbl   = bus.ctrl[OPC_BIT_DOUBLER];                   // RULE_06
  assign bus.abl   = bus.ctrl[OPC_BIT_ABL_SW] ? bus.ctrl[OPC_ABL_HI:OPC_ABL_LO]
                                               : OPC_ABL_HIGH;    // RULE_07
  assign bus.cpm   = bus.ctrl[OPC_CPM_HI:OPC_CPM_LO];             // RULE_10
endmodule : opc_decode

// >>> verilog/opc_if.sv
`timescale 1ns/1ps
interface opc_if;
  logic [7:0] ctrl;
  logic [7:0] fb;
  logic       ld_pd;
  logic       dbl;
  logic [1:0] abl;
  logic [1:0] cpm;
  logic [7:0] n_div;
  modport regs (output ctrl, output fb, input ld_pd, input dbl, input abl, input cpm,
                input n_div);
  modport dec  (input ctrl, input fb, output ld_pd, output dbl, output abl, output cpm,
                output n_div);
endinterface : opc_if

// >>> verilog/opc_output_pll_control.sv
`timescale 1ns/1ps
// Function
// RULE_01 - 8-bit charge pump current, about 3.5 uA per code, 900 uA full scale.
// RULE_02 - Feedback divide N = 4*B + A; A in bits 7:6, B in 5:0.
// RULE_03 - Software uses only allowed A/B pairs, N up to 255.
// RULE_04 - Control bit 7 set powers down lock detector.
// RULE_05 - Software always writes zero to control bit 6.
// RULE_06 - Control bit 5 set doubles the reference frequency.
// RULE_07 - Bit 4 clear forces antibacklash high; set uses field.
// RULE_08 - Software should set bit 4 to use the programmed field.
// RULE_09 - Antibacklash 00 min, 01 low, 10 high, 11 max; high initially.
// RULE_10 - Pump mode 00 tristate, 01 up, 10 down, 11 normal; resets 11.
module opc_output_pll_control (
  input  wire logic                      clock_in,
  input  wire logic                      rst_b_in,
  input  wire logic                      wr_en_in,
  input  wire logic                      rd_en_in,
  input  wire logic [opc_pkg::OPC_ADDR_W-1:0] addr_in,
  input  wire logic [opc_pkg::OPC_DATA_W-1:0] wdata_in,
  output logic      [opc_pkg::OPC_DATA_W-1:0] rdata_out,
  output logic      [7:0]                cp_current_out,
  output logic      [7:0]                fb_n_out,
  output logic                           lock_det_pd_out,
  output logic                           ref_doubler_out,
  output logic      [1:0]                antibacklash_out,
  output logic      [1:0]                cp_mode_out
);
  import opc_pkg::*;

  // ==========================================================================
  // Local constants
  localparam int                    NUM_REGS   = 3;
  localparam int                    IDX_W      = 2;
  localparam int                    IDX_CP     = 0;
  localparam int                    IDX_FB     = 1;
  localparam int                    IDX_CTRL   = 2;
  localparam logic [OPC_DATA_W-1:0] RDATA_IDLE = '0;

  // Output levels while reset is held, derived from the register reset values; antibacklash is set straight to OPC_ABL_HIGH
  localparam logic [7:0] FB_N_RST  = (8'(OPC_RST_FB_DIV[OPC_B_HI:OPC_B_LO]) << OPC_N_SHIFT)
                                   + 8'(OPC_RST_FB_DIV[OPC_A_HI:OPC_A_LO]);
  localparam logic       LD_PD_RST = OPC_RST_CONTROL[OPC_BIT_LD_PD];
  localparam logic       DBL_RST   = OPC_RST_CONTROL[OPC_BIT_DOUBLER];
  localparam logic [1:0] ABL_RST   = OPC_ABL_HIGH;
  localparam logic [1:0] CPM_RST   = OPC_RST_CONTROL[OPC_CPM_HI:OPC_CPM_LO];

  // ==========================================================================
  // Address decode
  // Shared by the write and read paths so both agree on the map

  function automatic logic addr_mapped(input logic [OPC_ADDR_W-1:0] addr);
    logic hit;
    hit = (addr == OPC_ADDR_CP_CURRENT)
       || (addr == OPC_ADDR_FB_DIV)
       || (addr == OPC_ADDR_CONTROL);
    return hit;
  endfunction : addr_mapped

  function automatic logic [IDX_W-1:0] addr_index(input logic [OPC_ADDR_W-1:0] addr);
    logic [IDX_W-1:0] idx;
    idx = IDX_W'(IDX_CP);
    if (addr == OPC_ADDR_FB_DIV) begin
      idx = IDX_W'(IDX_FB);
    end
    if (addr == OPC_ADDR_CONTROL) begin
      idx = IDX_W'(IDX_CTRL);
    end
    return idx;
  endfunction : addr_index

  wire             addr_ok   = addr_mapped(addr_in);
  wire             wr_mapped = wr_en_in && addr_mapped(addr_in);
  wire [IDX_W-1:0] sel_idx   = addr_index(addr_in);

  // ==========================================================================
  // Register storage
  // One flip-flop word per register; unmapped writes reach none of them

  wire [OPC_DATA_W-1:0] reg_word [NUM_REGS];

  for (genvar gi = 0; gi < NUM_REGS; gi++) begin : g_reg
    localparam logic [OPC_DATA_W-1:0] RST_VALUE = (gi == IDX_CP) ? OPC_RST_CP_CURRENT :
                                                  (gi == IDX_FB) ? OPC_RST_FB_DIV :
                                                                   OPC_RST_CONTROL;  // RULE_09 RULE_10

    logic [OPC_DATA_W-1:0] value;
    wire                   wr_hit = wr_mapped && (sel_idx == IDX_W'(gi));

    always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        value <= RST_VALUE;
      end else if (wr_hit) begin
        value <= wdata_in;
      end
    end

    assign reg_word[gi] = value;
  end

  // Named views of the storage words
  wire [7:0] charge_pump_current     = reg_word[IDX_CP];    // RULE_01
  wire [7:0] feedback_divider_counts = reg_word[IDX_FB];    // RULE_02
  wire [7:0] output_pll_control      = reg_word[IDX_CTRL];  // RULE_04 RULE_06 RULE_07

  // ==========================================================================
  // Read path
  // Read data holds until the next read strobe

  wire [OPC_DATA_W-1:0] next_rdata = addr_ok ? reg_word[sel_idx] : RDATA_IDLE;

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_out <= RDATA_IDLE;
    end else if (rd_en_in) begin
      rdata_out <= next_rdata;
    end
  end

  // ==========================================================================
  // Field decode
  // Decoding lives in its own module behind the carrier interface

  opc_if dec_if ();

  assign dec_if.ctrl = output_pll_control;
  assign dec_if.fb   = feedback_divider_counts;

  opc_decode u_decode (
    .bus (dec_if.dec)
  );

  // ==========================================================================
  // Registered outputs
  // Each output comes straight from a flip-flop, one cycle after its register

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cp_current_out <= OPC_RST_CP_CURRENT;
    end else begin
      cp_current_out <= charge_pump_current;  // RULE_01
    end
  end

  // Feedback divide ratio
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fb_n_out <= FB_N_RST;
    end else begin
      fb_n_out <= dec_if.n_div;  // RULE_02
    end
  end

  // Lock detector power-down
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lock_det_pd_out <= LD_PD_RST;
    end else begin
      lock_det_pd_out <= dec_if.ld_pd;  // RULE_04
    end
  end

  // Reference doubler enable
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ref_doubler_out <= DBL_RST;
    end else begin
      ref_doubler_out <= dec_if.dbl;  // RULE_06
    end
  end

  // Effective antibacklash width, forced high until software takes control
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      antibacklash_out <= ABL_RST;
    end else begin
      antibacklash_out <= dec_if.abl;  // RULE_07 RULE_09
    end
  end

  // Charge pump mode
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cp_mode_out <= CPM_RST;
    end else begin
      cp_mode_out <= dec_if.cpm;  // RULE_10
    end
  end

  // ==========================================================================
  // Notes for users
  // No legality check is made on the divider pair or the reserved bit;
  // whatever software writes is stored and decoded as written.
  // A write and a read in one cycle return the value held before the write.
endmodule : opc_output_pll_control

// >>> verilog/opc_pkg.sv
package opc_pkg;
  // ==========================================================================
  // Register map
  localparam logic [9:0] OPC_ADDR_CP_CURRENT = 10'h0f0;
  localparam logic [9:0] OPC_ADDR_FB_DIV     = 10'h0f1;
  localparam logic [9:0] OPC_ADDR_CONTROL    = 10'h0f2;
  localparam int         OPC_ADDR_W          = 10;
  localparam int         OPC_DATA_W          = 8;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] OPC_RST_CP_CURRENT  = 8'h00;
  localparam logic [7:0] OPC_RST_FB_DIV      = 8'h00;
  localparam logic [7:0] OPC_RST_CONTROL     = 8'h0b;

  // ==========================================================================
  // Field positions
  localparam int OPC_A_HI        = 7;
  localparam int OPC_A_LO        = 6;
  localparam int OPC_B_HI        = 5;
  localparam int OPC_B_LO        = 0;
  localparam int OPC_BIT_LD_PD   = 7;
  localparam int OPC_BIT_RSVD    = 6;
  localparam int OPC_BIT_DOUBLER = 5;
  localparam int OPC_BIT_ABL_SW  = 4;
  localparam int OPC_ABL_HI      = 3;
  localparam int OPC_ABL_LO      = 2;
  localparam int OPC_CPM_HI      = 1;
  localparam int OPC_CPM_LO      = 0;

  // ==========================================================================
  // Encodings
  typedef enum logic [1:0] {
    OPC_ABL_MIN  = 2'h0,
    OPC_ABL_LOW  = 2'h1,
    OPC_ABL_HIGH = 2'h2,
    OPC_ABL_MAX  = 2'h3
  } opc_abl_e;

  typedef enum logic [1:0] {
    OPC_CPM_TRISTATE = 2'h0,
    OPC_CPM_UP       = 2'h1,
    OPC_CPM_DOWN     = 2'h2,
    OPC_CPM_NORMAL   = 2'h3
  } opc_cpm_e;

  localparam logic [2:0] OPC_N_SHIFT = 3'h2;
endpackage : opc_pkg
